// ### src/adc_seq_pkg.sv
// Constants of the converter control sequencer: timing counts and the
// register map. Assumes one 10 MHz system clock and an APB register port.
// Summary of operation
// R01 - With convert request and calibrate select both high, calibration starts within two master clocks plus 200 ns.
// R02 - A calibration ends 3246 master clocks after its start, and result ready is then signalled.
// R03 - A rising convert request with calibrate select low starts a conversion within two master clocks plus 200 ns.
// R04 - A single conversion ends 1624 master clocks after its start.
// R05 - While convert request stays high, conversions follow back to back and each lasts 1622 master clocks.
// R06 - Pulsing calibrate select high while convert request is already high also starts a calibration.
// R07 - The host holds convert request high for at least 100 ns while calibrate select is high.
// R08 - An internal power-on reset of typically 10 ms runs at power-up and on leaving sleep.
// R09 - After reset the device waits 1800 master clocks, counted from oscillator start or, with external clock, from reset end.
// R10 - The host keeps the polarity select stable from 82 master clocks before result ready falls until that edge.
// R11 - The channel select inputs are latched on the rising edge of convert request.
// R12 - Result ready is driven low when a conversion or calibration finishes with a new word.
package adc_seq_pkg;
  // Clock and master clock rates
  localparam int CLK_HZ = 10_000_000;
  localparam int MCLK_HZ = 32768;
  localparam int MCLK_DIV = CLK_HZ / MCLK_HZ;
  // Power-on reset time and its cycle count
  localparam int POR_TIME_MS = 10;
  localparam int POR_CYCLES = POR_TIME_MS * (CLK_HZ / 1000);
  // Sequence lengths in master clocks
  localparam int WAKE_MCLKS = 1800;
  localparam int CAL_MCLKS = 3246;
  localparam int CONVERT_REQUEST_FIRST_MCLKS = 1624;
  localparam int CONVERT_REQUEST_CONT_MCLKS = 1622;
  localparam int SEQ_CNT_W = 12;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_INT_STATUS = 8'h08;
  localparam logic [7:0] REG_INT_MASK = 8'h0C;
  // Control fields and reset values
  localparam int CTRL_SLEEP_BIT = 0;
  localparam int CTRL_EXTCLK_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;
  // Status fields
  localparam int ST_POR_BIT = 0;
  localparam int ST_WAKE_BIT = 1;
  localparam int ST_CAL_BIT = 2;
  localparam int ST_CONVERT_REQUEST_BIT = 3;
  localparam int ST_READY_BIT = 4;
  localparam int ST_POL_BIT = 5;
  localparam int ST_CHAN_LSB = 6;
  // Interrupt event bits
  localparam int IRQ_CAL_BIT = 0;
  localparam int IRQ_CONVERT_REQUEST_BIT = 1;
  localparam int IRQ_WAKE_BIT = 2;
  localparam int IRQ_W = 3;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
endpackage

// ### src/mclk_tick_if.sv
// Carries the master clock enable pulse between divider and sequencer.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface mclk_tick_if;
  logic run;
  logic tick;
  modport src (input run, output tick);
  modport dst (output run, input tick);
endinterface

// ### src/mclk_divider.sv
// Master clock divider: one-cycle enable pulse every DIV system clocks.
// Assumes the sequencer stops it in sleep and, in crystal mode, while the oscillator is not running.
`timescale 1ns/1ps
module mclk_divider #(
  parameter int DIV = 305
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  mclk_tick_if.src mclk
);
  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  if (DIV < 2) begin : g_chk
    $error("mclk_divider: DIV must be at least 2");
  end

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  // Counter restarts while stopped so the first tick is a full period away
  always_comb begin
    cnt_nxt = '0;
    tick_nxt = 1'b0;
    if (mclk.run) begin
      if (cnt_r == LAST) begin
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + CW'(1);
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign mclk.tick = tick_r;
endmodule

// ### src/adc_sequencer.sv
// Converter control sequencer: power-on reset, wake-up, calibration and
// conversion timing, driven by host pins, with an APB register port.
// Assumes pins are asynchronous to clk_in and the APB master is on clk_in.
`timescale 1ns/1ps
module adc_sequencer
  import adc_seq_pkg::*;
#(
  parameter int MCLK_DIVIDE = MCLK_DIV,
  parameter int POR_COUNT = POR_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Host pins
  input wire logic convert_request_in,
  input wire logic cal_select_in,
  input wire logic [1:0] channel_select_in,
  input wire logic polarity_select_in,
  input wire logic osc_running_in,
  output logic result_ready_n_out,
  output logic [1:0] channel_out,
  output logic polarity_out,
  output logic calibrating_out,
  output logic converting_out,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic irq_out
);
  localparam int PW = $clog2(POR_COUNT + 1);
  localparam logic [PW-1:0] POR_LAST = PW'(POR_COUNT - 1);
  localparam int NPIN = 6;

  if (POR_COUNT < 1 || MCLK_DIVIDE < 2) begin : g_chk
    $error("adc_sequencer: POR_COUNT must be >= 1 and MCLK_DIVIDE >= 2");
  end

  typedef enum logic [2:0] {
    S_POR,
    S_WAKE,
    S_IDLE,
    S_CAL,
    S_CONVERT_REQUEST
  } seq_state_t;

  mclk_tick_if mclk ();

  mclk_divider #(
    .DIV(MCLK_DIVIDE)
  ) u_div (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .mclk(mclk.src)
  );

  // Two-flop synchronisers, one per pin
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] meta_r;
  logic [NPIN-1:0] sync_r;
  assign pin_raw = {osc_running_in, polarity_select_in, channel_select_in,
                    cal_select_in, convert_request_in};

  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        meta_r[i] <= 1'b0;
        sync_r[i] <= 1'b0;
      end else begin
        meta_r[i] <= pin_raw[i];
        sync_r[i] <= meta_r[i];
      end
    end
  end

  logic convert_request_s;
  logic cal_s;
  logic [1:0] chan_s;
  logic pol_s;
  logic osc_s;
  assign convert_request_s = sync_r[0];
  assign cal_s = sync_r[1];
  assign chan_s = sync_r[3:2];
  assign pol_s = sync_r[4];
  assign osc_s = sync_r[5];

  // Sequencer state
  seq_state_t state_r;
  seq_state_t state_nxt;
  logic [PW-1:0] por_cnt_r;
  logic [PW-1:0] por_cnt_nxt;
  logic [SEQ_CNT_W-1:0] cnt_r;
  logic [SEQ_CNT_W-1:0] cnt_nxt;
  logic convert_request_q_r;
  logic cal_q_r;
  logic cal_req_r;
  logic cal_req_nxt;
  logic convert_request_req_r;
  logic convert_request_req_nxt;
  logic [1:0] chan_r;
  logic [1:0] chan_nxt;
  logic pol_r;
  logic pol_nxt;
  logic ready_n_r;
  logic ready_n_nxt;
  logic cal_done;
  logic convert_request_done;
  logic wake_done;

  // Registers seen by software
  logic [1:0] ctrl_r;
  logic [1:0] ctrl_nxt;
  logic [IRQ_W-1:0] int_stat_r;
  logic [IRQ_W-1:0] int_stat_nxt;
  logic [IRQ_W-1:0] int_mask_r;
  logic [IRQ_W-1:0] int_mask_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic sleep_q_r;

  logic sleep;
  logic ext_clk;
  logic convert_request_rise;
  logic cal_rise;
  logic cal_event;
  logic convert_request_event;
  logic tick;
  logic cnt_end;

  assign sleep = ctrl_r[CTRL_SLEEP_BIT];
  assign ext_clk = ctrl_r[CTRL_EXTCLK_BIT];
  assign tick = mclk.tick;
  assign convert_request_rise = convert_request_s & ~convert_request_q_r;
  assign cal_rise = cal_s & ~cal_q_r;
  // Either order of the two pins requests a calibration; the host's
  // minimum pulse is one system clock, so no edge escapes the sampler
  assign cal_event = (convert_request_rise & cal_s) | (cal_rise & convert_request_s); // R01 R06 R07
  assign convert_request_event = convert_request_rise & ~cal_s; // R03
  assign cnt_end = tick && (cnt_r == SEQ_CNT_W'(1));

  // Crystal mode ticks only once the oscillator runs; sleep stops them
  assign mclk.run = ~sleep & (ext_clk | osc_s); // R09

  // Next state of the sequencer
  always_comb begin
    state_nxt = state_r;
    por_cnt_nxt = por_cnt_r;
    cnt_nxt = cnt_r;
    chan_nxt = chan_r;
    pol_nxt = pol_r;
    ready_n_nxt = ready_n_r;
    cal_done = 1'b0;
    convert_request_done = 1'b0;
    wake_done = 1'b0;
    // A new request outweighs the clear of the one being accepted
    cal_req_nxt = cal_req_r;
    convert_request_req_nxt = convert_request_req_r;
    if (convert_request_rise) begin
      chan_nxt = chan_s; // R11
    end
    if (tick && state_r != S_POR && state_r != S_WAKE) begin
      cnt_nxt = cnt_r - SEQ_CNT_W'(1);
    end
    unique case (state_r)
      S_POR: begin
        ready_n_nxt = 1'b1;
        cal_req_nxt = 1'b0;
        convert_request_req_nxt = 1'b0;
        if (!sleep) begin
          if (por_cnt_r == POR_LAST) begin // R08
            state_nxt = S_WAKE;
            cnt_nxt = SEQ_CNT_W'(WAKE_MCLKS);
          end else begin
            por_cnt_nxt = por_cnt_r + PW'(1);
          end
        end
      end
      S_WAKE: begin
        // Counts only master clocks, so crystal mode waits for the oscillator
        if (tick) begin
          cnt_nxt = cnt_r - SEQ_CNT_W'(1);
          if (cnt_r == SEQ_CNT_W'(1)) begin // R09
            state_nxt = S_IDLE;
            wake_done = 1'b1;
          end
        end
      end
      S_IDLE: begin
        // Start on the next master clock: at most two system clocks of
        // synchroniser, one of request register plus one master clock after the pin edge
        if (tick && cal_req_r) begin // R01 R06
          state_nxt = S_CAL;
          cnt_nxt = SEQ_CNT_W'(CAL_MCLKS);
          cal_req_nxt = 1'b0;
          convert_request_req_nxt = 1'b0;
          ready_n_nxt = 1'b1;
        end else if (tick && convert_request_req_r) begin // R03
          state_nxt = S_CONVERT_REQUEST;
          cnt_nxt = SEQ_CNT_W'(CONVERT_REQUEST_FIRST_MCLKS); // R04
          convert_request_req_nxt = 1'b0;
          ready_n_nxt = 1'b1;
        end
      end
      S_CAL: begin
        if (cnt_end) begin // R02
          state_nxt = S_IDLE;
          cal_done = 1'b1;
          ready_n_nxt = 1'b0; // R12
        end
      end
      S_CONVERT_REQUEST: begin
        // A back-to-back run raises ready one master clock before each new
        // word, so the host still sees one falling edge per result
        if (tick && cnt_r == SEQ_CNT_W'(2)) begin
          ready_n_nxt = 1'b1; // R12
        end
        if (cnt_end) begin
          convert_request_done = 1'b1;
          ready_n_nxt = 1'b0; // R12
          // Polarity is applied to the finished word as ready falls
          pol_nxt = pol_s; // R10
          if (convert_request_s && !cal_s && !cal_req_r) begin
            cnt_nxt = SEQ_CNT_W'(CONVERT_REQUEST_CONT_MCLKS); // R05
          end else begin
            state_nxt = S_IDLE;
          end
        end
      end
    endcase
    if (cal_event) begin
      cal_req_nxt = 1'b1;
    end
    if (convert_request_event) begin
      convert_request_req_nxt = 1'b1;
    end
    // Entering sleep or leaving it both restart the power-on reset
    if (sleep || sleep_q_r) begin // R08
      state_nxt = S_POR;
      por_cnt_nxt = '0;
      cal_req_nxt = 1'b0;
      convert_request_req_nxt = 1'b0;
      ready_n_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= S_POR;
      por_cnt_r <= '0;
      cnt_r <= '0;
      convert_request_q_r <= 1'b0;
      cal_q_r <= 1'b0;
      cal_req_r <= 1'b0;
      convert_request_req_r <= 1'b0;
      chan_r <= 2'h0;
      pol_r <= 1'b0;
      ready_n_r <= 1'b1;
      sleep_q_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      por_cnt_r <= por_cnt_nxt;
      cnt_r <= cnt_nxt;
      convert_request_q_r <= convert_request_s;
      cal_q_r <= cal_s;
      cal_req_r <= cal_req_nxt;
      convert_request_req_r <= convert_request_req_nxt;
      chan_r <= chan_nxt;
      pol_r <= pol_nxt;
      ready_n_r <= ready_n_nxt;
      sleep_q_r <= sleep;
    end
  end

  // APB decode: zero wait states, read data prepared in the setup cycle
  logic apb_wr;
  logic apb_rd_setup;
  logic addr_ok;
  assign apb_wr = psel_in & penable_in & pwrite_in;
  assign apb_rd_setup = psel_in & ~penable_in & ~pwrite_in;
  assign addr_ok = (paddr_in == REG_CTRL) || (paddr_in == REG_STATUS) ||
                   (paddr_in == REG_INT_STATUS) || (paddr_in == REG_INT_MASK);

  // Next values of the software registers
  always_comb begin
    ctrl_nxt = ctrl_r;
    int_mask_nxt = int_mask_r;
    int_stat_nxt = int_stat_r;
    rdata_nxt = rdata_r;
    if (apb_wr && paddr_in == REG_CTRL) begin
      ctrl_nxt = pwdata_in[1:0];
    end
    if (apb_wr && paddr_in == REG_INT_MASK) begin
      int_mask_nxt = pwdata_in[IRQ_W-1:0];
    end
    if (apb_wr && paddr_in == REG_INT_STATUS) begin
      int_stat_nxt = int_stat_r & ~pwdata_in[IRQ_W-1:0];
    end
    // Events are applied after the clear so a same-cycle event survives
    int_stat_nxt[IRQ_CAL_BIT] = int_stat_nxt[IRQ_CAL_BIT] | cal_done;
    int_stat_nxt[IRQ_CONVERT_REQUEST_BIT] = int_stat_nxt[IRQ_CONVERT_REQUEST_BIT] | convert_request_done;
    int_stat_nxt[IRQ_WAKE_BIT] = int_stat_nxt[IRQ_WAKE_BIT] | wake_done;
    if (apb_rd_setup) begin
      rdata_nxt = 32'h0000_0000;
      unique case (paddr_in)
        REG_CTRL: rdata_nxt[1:0] = ctrl_r;
        REG_STATUS: begin
          rdata_nxt[ST_POR_BIT] = (state_r == S_POR);
          rdata_nxt[ST_WAKE_BIT] = (state_r == S_WAKE);
          rdata_nxt[ST_CAL_BIT] = (state_r == S_CAL);
          rdata_nxt[ST_CONVERT_REQUEST_BIT] = (state_r == S_CONVERT_REQUEST);
          rdata_nxt[ST_READY_BIT] = ~ready_n_r;
          rdata_nxt[ST_POL_BIT] = pol_r;
          rdata_nxt[ST_CHAN_LSB +: 2] = chan_r;
        end
        REG_INT_STATUS: rdata_nxt[IRQ_W-1:0] = int_stat_r;
        REG_INT_MASK: rdata_nxt[IRQ_W-1:0] = int_mask_r;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_r <= CTRL_RESET;
      int_stat_r <= IRQ_RESET;
      int_mask_r <= IRQ_RESET;
      rdata_r <= 32'h0000_0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      int_stat_r <= int_stat_nxt;
      int_mask_r <= int_mask_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Outputs
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~addr_ok;
  assign prdata_out = rdata_r;
  assign irq_out = |(int_stat_r & int_mask_r);
  assign result_ready_n_out = ready_n_r;
  assign channel_out = chan_r;
  assign polarity_out = pol_r;
  assign calibrating_out = (state_r == S_CAL);
  assign converting_out = (state_r == S_CONVERT_REQUEST);
endmodule

// ### test/adc_host_model.sv
// Host model: drives the control, channel and polarity pins of the sequencer.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps
module adc_host_model (
  input wire logic clk_in,
  output logic convert_request_out,
  output logic cal_out,
  output logic [1:0] chan_out,
  output logic pol_out
);
  initial begin
    convert_request_out = 1'b0;
    cal_out = 1'b0;
    chan_out = 2'h0;
    pol_out = 1'b0;
  end
  // Channel is set a cycle ahead and inverted after the hold, so a late latch shows
  task automatic req(input logic [1:0] ch, input logic cl, input logic keep);
    @(posedge clk_in);
    chan_out <= ch;
    cal_out <= cl;
    @(posedge clk_in);
    convert_request_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    cal_out <= 1'b0;
    chan_out <= ~ch;
    convert_request_out <= keep;
  endtask
  task automatic set(input logic cv, input logic cl);
    @(posedge clk_in);
    convert_request_out <= cv;
    cal_out <= cl;
  endtask
  // Polarity only moves just after a result, far from the next one
  task automatic set_pol(input logic p);
    @(posedge clk_in);
    pol_out <= p;
  endtask
endmodule

// ### test/adc_seq_props.sv
// Checker of the sequencer ports: operation lengths, start delay, APB answers.
// Assumes the host keeps its pins stable around requests and results.
`timescale 1ns/1ps
module adc_seq_props #(
  parameter int MCLK_DIVIDE = 4
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic convert_request_in,
  input wire logic [1:0] channel_select_in,
  input wire logic polarity_select_in,
  input wire logic result_ready_n_out,
  input wire logic [1:0] channel_out,
  input wire logic polarity_out,
  input wire logic calibrating_out,
  input wire logic converting_out,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [7:0] paddr_in,
  input wire logic pready_out,
  input wire logic pslverr_out
);
  localparam int LAT = MCLK_DIVIDE + 3;
  logic busy;
  logic cont_r;
  logic [19:0] cnt_r;
  logic [1:0] ch_r;
  assign busy = calibrating_out | converting_out;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Count restarts at each start and each result, so back-to-back lengths show
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= 20'h0;
      cont_r <= 1'b0;
      ch_r <= 2'h0;
    end else begin
      cnt_r <= ($rose(busy) || $fell(result_ready_n_out)) ? 20'h1 : cnt_r + 20'h1;
      cont_r <= $fell(result_ready_n_out) ? converting_out : ($rose(busy) ? 1'b0 : cont_r);
      if ($rose(convert_request_in)) ch_r <= channel_select_in;
    end
  end
  sequence done_s;
    $fell(result_ready_n_out);
  endsequence
  sequence req_s;
    $rose(convert_request_in) && !busy && !result_ready_n_out;
  endsequence
  AST_CAL_LEN: assert property ($past(calibrating_out) ##0 done_s |-> cnt_r == 3246 * MCLK_DIVIDE)
    else $error("calibration length wrong");
  AST_CONVERT_REQUEST_LEN: assert property ($past(converting_out) && !cont_r ##0 done_s |-> cnt_r == 1624 * MCLK_DIVIDE)
    else $error("conversion length wrong");
  AST_CONT_LEN: assert property ($past(converting_out) && cont_r ##0 done_s |-> cnt_r == 1622 * MCLK_DIVIDE)
    else $error("repeated conversion length wrong");
  AST_START: assert property (req_s |-> ##[1:LAT] busy)
    else $error("operation start late");
  AST_POL: assert property ($past(converting_out) ##0 done_s |-> ##[0:2] polarity_out == polarity_select_in)
    else $error("polarity not applied");
  AST_CHAN: assert property ($rose(busy) |-> channel_out == ch_r)
    else $error("channel not latched");
  AST_READY: assert property (done_s |-> $past(busy))
    else $error("result ready without operation");
  AST_PREADY: assert property (psel_in && penable_in |-> pready_out)
    else $error("access not answered");
  AST_SLVERR: assert property (psel_in && penable_in && paddr_in > 8'h0C |-> pslverr_out)
    else $error("unmapped access not flagged");
endmodule
bind adc_sequencer adc_seq_props #(.MCLK_DIVIDE(MCLK_DIVIDE)) adc_seq_props_inst (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .convert_request_in(convert_request_in),
  .channel_select_in(channel_select_in), .polarity_select_in(polarity_select_in),
  .result_ready_n_out(result_ready_n_out), .channel_out(channel_out), .polarity_out(polarity_out),
  .calibrating_out(calibrating_out), .converting_out(converting_out), .psel_in(psel_in),
  .penable_in(penable_in), .paddr_in(paddr_in), .pready_out(pready_out), .pslverr_out(pslverr_out)
);

// ### test/adc_sequencer_tb.sv
// Testbench of the sequencer: APB registers, wake-up and host pin sequences.
// Assumes the host model and the port checker are compiled first.
`timescale 1ns/1ps
module adc_sequencer_tb;
  import adc_seq_pkg::*;
  localparam int DIV = 4;
  localparam int POR = 20;
  logic clk_in, rst_n_in, psel, penable, pwrite, pslverr, pready, irq, convert_request, cal, pol;
  logic rdy_n, pol_o, cal_o, convert_request_o, lc, rdy_q, p, e, osc;
  logic [1:0] chs, ch_o, ch;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] ex;
  logic [3:0] exp_q[$];
  int num_errors, checked, done, cyc, t0;
  adc_sequencer #(.MCLK_DIVIDE(DIV), .POR_COUNT(POR)) adc_sequencer_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .convert_request_in(convert_request), .cal_select_in(cal),
    .channel_select_in(chs), .polarity_select_in(pol), .osc_running_in(osc),
    .result_ready_n_out(rdy_n), .channel_out(ch_o), .polarity_out(pol_o), .calibrating_out(cal_o),
    .converting_out(convert_request_o), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .irq_out(irq));
  adc_host_model adc_host_model_inst (.clk_in(clk_in), .convert_request_out(convert_request), .cal_out(cal),
    .chan_out(chs), .pol_out(pol));
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // Free cycle count; wake-up spans are measured from the edge that starts them
  always @(posedge clk_in) cyc <= cyc + 1;
  task automatic cmp(input string nm, input logic [31:0] exv, input logic [31:0] got);
    checked++;
    if (got !== exv) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exv, got);
    end
  endtask
  // One APB transfer; waits on pready, so a slower slave would also be served
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
    end while (pready !== 1'b1 && k < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exv);
    apb(1'b0, a, 32'h0);
    cmp("prdata", exv, r & m);
  endtask
  task automatic chk_irq(input logic exv);
    @(negedge clk_in);
    cmp("irq", {31'h0, exv}, {31'h0, irq});
  endtask
  task automatic wait_done(input int n);
    int k;
    k = 0;
    while (done < n && k < 20000) begin
      @(posedge clk_in);
      k++;
    end
    cmp("results", n, done);
  endtask
  // Span counts from the reset release, sleep exit or oscillator start at cycle from
  task automatic wake(input int from, input int base);
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 9000) begin
      @(posedge clk_in);
      k = cyc - from;
    end
    cmp("wake", 32'h1, {31'h0, k > base + WAKE_MCLKS * DIV - 8 && k < base + WAKE_MCLKS * DIV + 8});
    rd(REG_INT_STATUS, 32'h4, 32'h4);
  endtask
  // Oldest note is taken at each falling result ready; kind follows the last busy state
  always @(negedge clk_in) begin
    if (cal_o | convert_request_o) lc = cal_o;
    if (rdy_q && !rdy_n) begin
      done++;
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("mismatch result expected none seen %h", ch_o);
      end else begin
        ex = exp_q.pop_front();
        cmp("result", ex, {lc, ch_o, lc ? ex[0] : pol_o});
      end
    end
    rdy_q = rdy_n;
  end
  task automatic close_out();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #10_000_000;
    num_errors++;
    close_out();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, rst_n_in} = '0;
    {num_errors, checked, done, cyc, t0} = '0;
    osc = 1'b1;
    rdy_q = 1'b1;
    lc = 1'b0;
    void'($urandom(86));
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t0 = cyc;
    chk_irq(1'b0);
    cmp("ready_n", 32'h1, {31'h0, rdy_n});
    rd(REG_CTRL, 32'hFFFF_FFFF, {30'h0, CTRL_RESET});
    rd(REG_INT_MASK, 32'hFFFF_FFFF, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    cmp("unmapped", 32'h1, {r[30:0], e});
    apb(1'b1, REG_INT_MASK, 32'h7);
    wake(t0, POR);
    apb(1'b1, REG_INT_STATUS, 32'h4);
    chk_irq(1'b0);
    $display("test reset and wake-up done");
    ch = 2'($urandom());
    exp_q.push_back({1'b1, ch, 1'b0});
    adc_host_model_inst.req(ch, 1'b1, 1'b0);
    wait_done(1);
    rd(REG_INT_STATUS, 32'h1, 32'h1);
    chk_irq(1'b1);
    $display("test calibration done");
    for (int i = 0; i < 2; i++) begin
      p = 1'($urandom());
      adc_host_model_inst.set_pol(p);
      exp_q.push_back({1'b0, 2'(i), p});
      adc_host_model_inst.req(2'(i), 1'b0, 1'b0);
      wait_done(2 + i);
    end
    apb(1'b1, REG_INT_MASK, 32'h5);
    chk_irq(1'b1);
    apb(1'b1, REG_INT_STATUS, 32'h1);
    chk_irq(1'b0);
    rd(REG_INT_STATUS, 32'h7, 32'h2);
    apb(1'b1, REG_INT_MASK, 32'h7);
    chk_irq(1'b1);
    apb(1'b1, REG_INT_STATUS, 32'h7);
    chk_irq(1'b0);
    $display("test single conversions and interrupts done");
    adc_host_model_inst.set_pol(1'b1);
    exp_q.push_back(4'h7);
    exp_q.push_back(4'h6);
    exp_q.push_back(4'h7);
    adc_host_model_inst.req(2'h3, 1'b0, 1'b1);
    wait_done(4);
    adc_host_model_inst.set_pol(1'b0);
    wait_done(5);
    adc_host_model_inst.set_pol(1'b1);
    adc_host_model_inst.set(1'b0, 1'b0);
    wait_done(6);
    $display("test back-to-back conversions done");
    exp_q.push_back(4'h5);
    exp_q.push_back(4'hC);
    adc_host_model_inst.req(2'h2, 1'b0, 1'b1);
    repeat (8) @(posedge clk_in);
    adc_host_model_inst.set(1'b1, 1'b1);
    repeat (3) @(posedge clk_in);
    adc_host_model_inst.set(1'b0, 1'b0);
    wait_done(7);
    wait_done(8);
    $display("test calibration by pulse done");
    apb(1'b1, REG_CTRL, 32'h3);
    rd(REG_STATUS, 32'h1, 32'h1);
    apb(1'b1, REG_INT_STATUS, 32'h7);
    apb(1'b1, REG_CTRL, 32'h2);
    t0 = cyc;
    wake(t0, POR);
    $display("test sleep and wake-up done");
    // Crystal mode: no master clocks, hence no wake-up, until the oscillator runs
    apb(1'b1, REG_CTRL, 32'h1);
    osc <= 1'b0;
    apb(1'b1, REG_INT_STATUS, 32'h7);
    apb(1'b1, REG_CTRL, 32'h0);
    repeat (POR + 100) @(posedge clk_in);
    rd(REG_STATUS, 32'h3, 32'h2);
    chk_irq(1'b0);
    @(posedge clk_in);
    osc <= 1'b1;
    t0 = cyc;
    wake(t0, 0);
    cmp("pending", 32'h0, exp_q.size());
    $display("test crystal wake-up done");
    close_out();
  end
endmodule
